// *** src/stl_task_regs.sv ***
// segment, local table and task register file with task switch sequencer
`timescale 1ns/1ps
`include "stl_cfg.svh"
// Behaviour
// - segment, task, local registers hold selectors
// - selector: level bits 1:0, indicator 2, index
// - indicator zero global table, one local
// - task and local selectors must be global
// - larger requested level overrides current level
// - task register holds selector plus cached descriptor
// - switch saves old state, loads new task
// - call or interrupt switch marks both busy
// - cache refreshed from new descriptor automatically
// - enable bit one protected, zero real
// - base dword, word limit, byte rights, selector
module stl_task_regs (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [1:0] seg_wr_idx_i, // segment register to write
    input wire logic seg_wr_i, // write pulse for a segment register
    input wire stl_pkg::stl_seg_s seg_wr_data_i, // fields written
    input wire logic ldt_wr_i, // local table pointer register write
    input wire stl_pkg::stl_seg_s ldt_wr_data_i, // local table fields
    input wire logic msw_wr_i, // machine status word write
    input wire logic [15:0] msw_wr_data_i, // machine status word value
    input wire logic [1:0] cur_pl_i, // current privilege level
    input wire logic sw_req_i, // task switch request pulse
    input wire logic sw_call_i, // switch caused by call or interrupt
    input wire logic [15:0] sw_sel_i, // incoming task selector
    input wire stl_pkg::stl_seg_s sw_desc_i, // incoming descriptor fields
    input wire logic [7:0] old_access_i, // outgoing descriptor access byte
    input wire logic [15:0] state_word_i [`STL_SAVE_WORDS], // state to save
    input wire logic protection_check_setting_i, // probe checking on
    input wire logic [1:0] view_idx_i, // segment register viewed
    output logic [15:0] seg_sel_o, // viewed selector, always visible
    output stl_pkg::stl_seg_s seg_hidden_o, // viewed hidden fields
    output stl_pkg::stl_seg_s ldt_hidden_o, // local table register fields
    output stl_pkg::stl_seg_s task_hidden_o, // task register fields
    output logic protection_enable_bit_o, // protected mode when high
    output logic [1:0] eff_pl_o, // effective level of viewed selector
    output logic tss_wr_o, // state segment write strobe
    output logic [15:0] tss_wr_sel_o, // state segment owner selector
    output logic [1:0] tss_wr_idx_o, // word slot in the state segment
    output logic [15:0] tss_wr_data_o, // word saved
    output logic desc_wr_o, // descriptor access byte write strobe
    output logic [15:0] desc_wr_sel_o, // descriptor written
    output logic [7:0] desc_wr_data_o, // access byte with busy set
    output logic sw_busy_o, // switch in progress
    output logic sw_err_o // switch refused: local selector
);
    stl_pkg::stl_seg_s seg_q [4]; // segment registers
    stl_pkg::stl_seg_s ldt_q; // local table pointer register
    stl_pkg::stl_seg_s task_q; // task pointer register and cache
    logic [15:0] machine_status_word; // machine status word
    stl_pkg::stl_state_e state; // sequencer state
    logic [`STL_SAVE_CNT_W-1:0] save_cnt; // save word counter
    logic [15:0] new_sel; // latched incoming selector
    stl_pkg::stl_seg_s new_desc; // latched incoming descriptor
    logic new_call; // latched call flag
    logic [7:0] new_access_busy; // incoming access byte with busy set
    stl_sel_if sif ();

    // returns an access byte with the task busy flag set
    function automatic logic [7:0] mark_busy(input logic [7:0] acc);
        mark_busy = acc | (8'h01 << `STL_BUSY_BIT);
    endfunction : mark_busy

    // hidden fields masked unless probe checking is off
    function automatic stl_pkg::stl_seg_s hide(input stl_pkg::stl_seg_s r,
                                               input logic chk);
        hide = chk ? '0 : r;
    endfunction : hide

    assign sif.sel = seg_q[view_idx_i].sel;
    assign sif.cur_pl = cur_pl_i;
    assign new_access_busy = mark_busy(new_desc.access);

    // selector decoder
    stl_sel_dec u_dec (
        .s (sif.dec)
    );

    // segment registers with all four fields
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < 4; i++) begin
                seg_q[i] <= '{`STL_BASE_RST, `STL_LIM_RST, `STL_AR_RST, `STL_SEL_RST};
            end
        end else if (seg_wr_i) begin
            seg_q[seg_wr_idx_i] <= seg_wr_data_i;
        end
    end

    // local table pointer register, global selectors only
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ldt_q <= '{`STL_BASE_RST, `STL_LIM_RST, `STL_AR_RST, `STL_SEL_RST};
        end else if (ldt_wr_i && ldt_wr_data_i.sel[`STL_TI_BIT] == `STL_TI_GLOBAL) begin
            ldt_q <= ldt_wr_data_i;
        end
    end

    // machine status word
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            machine_status_word <= `STL_MSW_RST;
        end else if (msw_wr_i) begin
            machine_status_word <= msw_wr_data_i;
        end
    end

    // task switch sequencer: save, mark busy, load
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= stl_pkg::ST_IDLE;
            save_cnt <= `STL_SAVE_ZERO;
            new_sel <= `STL_SEL_RST;
            new_desc <= '{`STL_BASE_RST, `STL_LIM_RST, `STL_AR_RST, `STL_SEL_RST};
            new_call <= 1'b0;
        end else begin
            case (state)
                stl_pkg::ST_IDLE: begin
                    // only global selectors start a switch
                    if (sw_req_i && sw_sel_i[`STL_TI_BIT] == `STL_TI_GLOBAL) begin
                        state <= stl_pkg::ST_SAVE;
                        save_cnt <= `STL_SAVE_ZERO;
                        new_sel <= sw_sel_i;
                        new_desc <= sw_desc_i;
                        new_call <= sw_call_i;
                    end
                end
                stl_pkg::ST_SAVE: begin
                    // store outgoing state word by word
                    if (save_cnt == `STL_SAVE_LAST) begin
                        state <= new_call ? stl_pkg::ST_MARK : stl_pkg::ST_LOAD;
                    end
                    save_cnt <= save_cnt + 1'b1;
                end
                stl_pkg::ST_MARK: begin
                    state <= stl_pkg::ST_LOAD;
                end
                stl_pkg::ST_LOAD: begin
                    state <= stl_pkg::ST_IDLE;
                end
                default: begin
                    state <= stl_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // task register: selector and cached descriptor
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            task_q <= '{`STL_BASE_RST, `STL_LIM_RST, `STL_AR_RST, `STL_SEL_RST};
        end else if (state == stl_pkg::ST_LOAD) begin
            task_q.sel <= new_sel;
            task_q.base <= new_desc.base;
            task_q.limit <= new_desc.limit;
            task_q.access <= new_call ? new_access_busy : new_desc.access;
        end
    end

    // state segment write port
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tss_wr_o <= 1'b0;
            tss_wr_sel_o <= `STL_SEL_RST;
            tss_wr_idx_o <= `STL_SAVE_ZERO;
            tss_wr_data_o <= 16'h0000;
        end else begin
            tss_wr_o <= (state == stl_pkg::ST_SAVE);
            tss_wr_sel_o <= task_q.sel;
            tss_wr_idx_o <= save_cnt;
            tss_wr_data_o <= state_word_i[save_cnt];
        end
    end

    // descriptor busy marking: outgoing in mark, incoming in load
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            desc_wr_o <= 1'b0;
            desc_wr_sel_o <= `STL_SEL_RST;
            desc_wr_data_o <= `STL_AR_RST;
        end else if (state == stl_pkg::ST_MARK) begin
            desc_wr_o <= 1'b1;
            desc_wr_sel_o <= task_q.sel;
            desc_wr_data_o <= mark_busy(old_access_i);
        end else if (state == stl_pkg::ST_LOAD && new_call) begin
            desc_wr_o <= 1'b1;
            desc_wr_sel_o <= new_sel;
            desc_wr_data_o <= new_access_busy;
        end else begin
            desc_wr_o <= 1'b0;
        end
    end

    // status and view outputs
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seg_sel_o <= `STL_SEL_RST;
            seg_hidden_o <= '0;
            ldt_hidden_o <= '0;
            task_hidden_o <= '0;
            protection_enable_bit_o <= 1'b0;
            eff_pl_o <= 2'h0;
            sw_busy_o <= 1'b0;
            sw_err_o <= 1'b0;
        end else begin
            seg_sel_o <= seg_q[view_idx_i].sel;
            seg_hidden_o <= hide(seg_q[view_idx_i], protection_check_setting_i);
            ldt_hidden_o <= hide(ldt_q, protection_check_setting_i);
            task_hidden_o <= hide(task_q, protection_check_setting_i);
            protection_enable_bit_o <= machine_status_word[`STL_PE_BIT];
            eff_pl_o <= sif.eff_pl;
            // busy from the edge that accepts a global request; the viewed segment plays no part
            sw_busy_o <= (state != stl_pkg::ST_IDLE) ||
                         (sw_req_i && sw_sel_i[`STL_TI_BIT] == `STL_TI_GLOBAL);
            sw_err_o <= (state == stl_pkg::ST_IDLE) && sw_req_i &&
                        sw_sel_i[`STL_TI_BIT] == `STL_TI_LOCAL;
        end
    end
endmodule : stl_task_regs

// *** src/stl_cfg.svh ***
// constants for the selector and task register block
`ifndef STL_CFG_SVH
`define STL_CFG_SVH
`define STL_RPL_LO 0
`define STL_RPL_HI 1
`define STL_TI_BIT 2
`define STL_IDX_LO 3
`define STL_IDX_HI 15
`define STL_TI_GLOBAL 1'b0
`define STL_TI_LOCAL 1'b1
`define STL_BUSY_BIT 1
`define STL_PE_BIT 0
`define STL_SEL_RST 16'h0000
`define STL_BASE_RST 32'h0000_0000
`define STL_LIM_RST 16'hffff
`define STL_AR_RST 8'h00
`define STL_MSW_RST 16'h0000
`define STL_SAVE_WORDS 4
`define STL_SAVE_CNT_W 2
`define STL_SAVE_LAST 2'h3
`define STL_SAVE_ZERO 2'h0
`endif

// *** src/stl_pkg.sv ***
// types for the selector and task register block
package stl_pkg;
    // segment style register: base, limit, access rights, selector
    typedef struct packed {
        logic [31:0] base;
        logic [15:0] limit;
        logic [7:0] access;
        logic [15:0] sel;
    } stl_seg_s;
    // task switch sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAVE = 2'b01,
        ST_MARK = 2'b10,
        ST_LOAD = 2'b11
    } stl_state_e;
endpackage : stl_pkg

// *** src/stl_sel_if.sv ***
// selector decode signals carried between the main block and its decoder
`timescale 1ns/1ps
interface stl_sel_if;
    logic [15:0] sel; // selector under test
    logic [1:0] cur_pl; // current privilege level
    logic local_tbl; // selector names the local table
    logic [12:0] index; // descriptor index
    logic [1:0] eff_pl; // effective privilege level
    modport req (output sel, output cur_pl, input local_tbl, input index, input eff_pl);
    modport dec (input sel, input cur_pl, output local_tbl, output index, output eff_pl);
endinterface : stl_sel_if

// *** src/stl_sel_dec.sv ***
// selector field decoder
`timescale 1ns/1ps
`include "stl_cfg.svh"
module stl_sel_dec (
    stl_sel_if.dec s
);
    // table indicator picks the table
    assign s.local_tbl = (s.sel[`STL_TI_BIT] == `STL_TI_LOCAL);
    // index field above the indicator
    assign s.index = s.sel[`STL_IDX_HI:`STL_IDX_LO];
    // larger requested level overrides the current one
    assign s.eff_pl = (s.sel[`STL_RPL_HI:`STL_RPL_LO] > s.cur_pl) ?
        s.sel[`STL_RPL_HI:`STL_RPL_LO] : s.cur_pl;
endmodule : stl_sel_dec

// *** sim/stl_task_regs_properties.sv ***
// port assertions for the selector and task register block
`timescale 1ns/1ps
module stl_task_regs_props (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic msw_wr_i,
    input wire logic [15:0] msw_wr_data_i,
    input wire logic sw_req_i,
    input wire logic [15:0] sw_sel_i,
    input wire logic protection_check_setting_i,
    input wire stl_pkg::stl_seg_s task_hidden_o,
    input wire logic protection_enable_bit_o,
    input wire logic tss_wr_o,
    input wire logic [1:0] tss_wr_idx_o,
    input wire logic desc_wr_o,
    input wire logic [7:0] desc_wr_data_o,
    input wire logic sw_busy_o,
    input wire logic sw_err_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    logic pe_ref; // last mode bit written
    // reference mode bit, tolerant of one or two output stages
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pe_ref <= 1'b0;
        end else if (msw_wr_i) begin
            pe_ref <= msw_wr_data_i[0];
        end
    end
    property p_err; sw_req_i && sw_sel_i[2] && !sw_busy_o |-> ##[1:2] sw_err_o; endproperty
    a_err: assert property (p_err) else $error("local selector not refused");
    property p_busy; sw_req_i && !sw_sel_i[2] && !sw_busy_o |-> ##[1:2] sw_busy_o; endproperty
    a_busy: assert property (p_busy) else $error("switch not started");
    property p_first; $rose(sw_busy_o) |-> ##[0:2] tss_wr_o && tss_wr_idx_o == 2'h0; endproperty
    a_first: assert property (p_first) else $error("first save word missing");
    property p_seq;
        tss_wr_o && tss_wr_idx_o != 2'h3 |=> tss_wr_o && tss_wr_idx_o == $past(tss_wr_idx_o) + 2'h1;
    endproperty
    a_seq: assert property (p_seq) else $error("save words out of order");
    property p_len; $rose(sw_busy_o) |-> sw_busy_o [*5] ##[1:12] !sw_busy_o; endproperty
    a_len: assert property (p_len) else $error("switch length wrong");
    property p_desc; desc_wr_o |-> desc_wr_data_o[1]; endproperty
    a_desc: assert property (p_desc) else $error("descriptor not marked busy");
    property p_hide;
        protection_check_setting_i && $past(protection_check_setting_i) |-> task_hidden_o == '0;
    endproperty
    a_hide: assert property (p_hide) else $error("hidden fields shown");
    property p_pe; $past(msw_wr_i) && !msw_wr_i |=> protection_enable_bit_o == pe_ref; endproperty
    a_pe: assert property (p_pe) else $error("mode bit wrong");
endmodule : stl_task_regs_props
bind stl_task_regs stl_task_regs_props u_props (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .msw_wr_i(msw_wr_i), .msw_wr_data_i(msw_wr_data_i), .sw_req_i(sw_req_i),
    .sw_sel_i(sw_sel_i), .protection_check_setting_i(protection_check_setting_i),
    .task_hidden_o(task_hidden_o), .protection_enable_bit_o(protection_enable_bit_o),
    .tss_wr_o(tss_wr_o), .tss_wr_idx_o(tss_wr_idx_o), .desc_wr_o(desc_wr_o),
    .desc_wr_data_o(desc_wr_data_o), .sw_busy_o(sw_busy_o), .sw_err_o(sw_err_o));

// *** sim/stl_far_model.sv ***
// outgoing task image source and state segment sink
`timescale 1ns/1ps
`include "stl_cfg.svh"
module stl_far_model (
    input wire logic clk_i,
    input wire logic tss_wr_i,
    input wire logic [15:0] tss_wr_data_i,
    input wire logic [15:0] tss_wr_sel_i,
    input wire logic [1:0] tss_wr_idx_i,
    input wire logic desc_wr_i,
    input wire logic [7:0] desc_wr_data_i,
    input wire logic [15:0] desc_wr_sel_i,
    output logic [15:0] word_o [`STL_SAVE_WORDS],
    output logic [7:0] old_access_o
);
    int tss_cnt = 0; // words stored into the state segment
    int desc_cnt = 0; // access bytes stored
    logic [15:0] last_word; // last word stored
    logic [7:0] last_acc; // last access byte stored
    logic [15:0] last_sel; // owner of the last state word stored
    logic [15:0] desc_sel [2]; // descriptors marked, in arrival order
    logic idx_bad = 1'b0; // a state word arrived out of slot order
    // register image of the outgoing task
    always_comb begin
        for (int i = 0; i < `STL_SAVE_WORDS; i++) begin
            word_o[i] = 16'ha000 + 16'(i);
        end
    end
    assign old_access_o = 8'h81; // outgoing descriptor, not yet busy
    // record what the block writes back
    always @(posedge clk_i) begin
        if (tss_wr_i === 1'b1) begin
            tss_cnt <= tss_cnt + 1;
            last_word <= tss_wr_data_i;
            last_sel <= tss_wr_sel_i;
            // four words per switch, slots 0 to 3 in order
            if (tss_wr_idx_i !== 2'(tss_cnt)) begin
                idx_bad <= 1'b1;
            end
        end
        if (desc_wr_i === 1'b1) begin
            desc_cnt <= desc_cnt + 1;
            last_acc <= desc_wr_data_i;
            desc_sel[desc_cnt % 2] <= desc_wr_sel_i;
        end
    end
endmodule : stl_far_model

// *** sim/stl_task_regs_tb_top.sv ***
// self-checking bench for the selector and task register block
`timescale 1ns/1ps
`include "stl_cfg.svh"
`define CHK(g, e) chk(72'(g), 72'(e))
module stl_task_regs_tb_top;
    typedef struct packed {logic [1:0] idx; logic [15:0] sel; logic [1:0] current_privilege_level, eff;} stl_row_s;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [1:0] wr_idx = 2'h0, view = 2'h0, current_privilege_level = 2'h0;
    logic seg_wr = 0, ldt_wr = 0, msw_wr = 0, req = 0, call = 0, chk_on = 0, err_seen = 0;
    logic [15:0] msw_d = 16'h0000, sel = 16'h0000;
    stl_pkg::stl_seg_s sd = '0, ld = '0, td = '0, seg_h, ldt_h, task_h;
    logic [15:0] words [`STL_SAVE_WORDS];
    logic [15:0] seg_sel, tss_d, tss_sel, desc_sel;
    logic [7:0] oacc, desc_d;
    logic [1:0] eff, tss_idx;
    logic pe, tss_wr, desc_wr, busy, err;
    int bad_count = 0;
    int cmp_count = 0;
    // segment writes with the expected view: selector, current and effective level
    stl_row_s rows [4] = '{'{2'h0, 16'h0013, 2'h0, 2'h3}, '{2'h1, 16'h0024, 2'h2, 2'h2},
        '{2'h2, 16'h002e, 2'h1, 2'h2}, '{2'h3, 16'hfff9, 2'h3, 2'h3}};
    stl_task_regs dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .seg_wr_idx_i(wr_idx),
        .seg_wr_i(seg_wr), .seg_wr_data_i(sd), .ldt_wr_i(ldt_wr), .ldt_wr_data_i(ld),
        .msw_wr_i(msw_wr), .msw_wr_data_i(msw_d), .cur_pl_i(current_privilege_level), .sw_req_i(req),
        .sw_call_i(call), .sw_sel_i(sel), .sw_desc_i(td), .old_access_i(oacc),
        .state_word_i(words), .protection_check_setting_i(chk_on), .view_idx_i(view),
        .seg_sel_o(seg_sel), .seg_hidden_o(seg_h), .ldt_hidden_o(ldt_h), .task_hidden_o(task_h),
        .protection_enable_bit_o(pe), .eff_pl_o(eff), .tss_wr_o(tss_wr), .tss_wr_sel_o(tss_sel),
        .tss_wr_idx_o(tss_idx), .tss_wr_data_o(tss_d), .desc_wr_o(desc_wr),
        .desc_wr_sel_o(desc_sel), .desc_wr_data_o(desc_d), .sw_busy_o(busy), .sw_err_o(err));
    stl_far_model far (.clk_i(clk_i), .tss_wr_i(tss_wr), .tss_wr_data_i(tss_d),
        .tss_wr_sel_i(tss_sel), .tss_wr_idx_i(tss_idx), .desc_wr_i(desc_wr),
        .desc_wr_data_i(desc_d), .desc_wr_sel_i(desc_sel), .word_o(words), .old_access_o(oacc));
    // free-running clock
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    // remember any refusal pulse
    always @(posedge clk_i) if (err === 1'b1) err_seen <= 1'b1;
    task automatic chk(input logic [71:0] g, input logic [71:0] e);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task nc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : nc
    // one switch request, then wait for the sequencer to go idle
    task sw(input logic [15:0] s, input logic c);
        int n;
        sel = s;
        call = c;
        req = 1'b1;
        @(negedge clk_i);
        req = 1'b0;
        n = 0;
        while (n < 20 && (n < 2 || busy !== 1'b0)) begin
            @(negedge clk_i);
            n++;
        end
        nc(2);
    endtask : sw
    task close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    // watchdog far beyond the expected run
    initial begin
        #50us;
        bad_count++;
        close_out();
    end
    initial begin
        nc(16);
        arst_n_i = 1'b1;
        nc(2);
        `CHK(task_h.limit, 16'hffff);
        `CHK(task_h.sel, 16'h0000);
        foreach (rows[i]) begin
            wr_idx = rows[i].idx;
            sd.sel = rows[i].sel;
            sd.base = {16'h0001, rows[i].sel};
            seg_wr = 1'b1;
            @(negedge clk_i);
            seg_wr = 1'b0;
            view = rows[i].idx;
            current_privilege_level = rows[i].current_privilege_level;
            nc(3);
            `CHK(seg_sel, rows[i].sel);
            `CHK(eff, rows[i].eff);
            `CHK(seg_h, sd);
        end
        for (int v = 1; v >= 0; v--) begin
            msw_d = 16'(v);
            msw_wr = 1'b1;
            @(negedge clk_i);
            msw_wr = 1'b0;
            nc(2);
            `CHK(pe, v[0]);
            `CHK(pe, msw_d[`STL_PE_BIT]);
        end
        for (int k = 0; k < 2; k++) begin
            ld.sel = k ? 16'h001c : 16'h0010;
            ldt_wr = 1'b1;
            @(negedge clk_i);
            ldt_wr = 1'b0;
            nc(2);
            `CHK(ldt_h.sel, 16'h0010);
        end
        // register edits alone never reach a state segment
        `CHK(far.tss_cnt, 0);
        // plain load first: outgoing task is the reset selector, nothing marked busy
        sw(16'h0070, 1'b0);
        `CHK(far.tss_cnt, 4);
        `CHK(far.last_word, 16'ha003);
        `CHK(far.last_sel, 16'h0000);
        `CHK(far.desc_cnt, 0);
        `CHK(task_h.sel, 16'h0070);
        // call switch: outgoing then incoming descriptor marked busy
        td = '{32'h0005_a000, 16'h002b, 8'h81, 16'h0068};
        sw(16'h0068, 1'b1);
        `CHK(far.tss_cnt, 8);
        `CHK(far.last_sel, 16'h0070);
        `CHK(far.idx_bad, 1'b0);
        `CHK(far.desc_cnt, 2);
        `CHK(far.desc_sel[0], 16'h0070);
        `CHK(far.desc_sel[1], 16'h0068);
        `CHK(far.last_acc, 8'h83);
        `CHK(task_h.sel, 16'h0068);
        `CHK(task_h.base, 32'h0005_a000);
        `CHK(task_h.access, 8'h83);
        // local selector is refused and changes nothing
        sw(16'h007c, 1'b0);
        `CHK(err_seen, 1'b1);
        `CHK(far.tss_cnt, 8);
        `CHK(task_h.sel, 16'h0068);
        chk_on = 1'b1;
        nc(3);
        `CHK(task_h, 72'h0);
        `CHK(seg_sel, 16'hfff9);
        // reset again in mid-run: task register back to its reset fields
        chk_on = 1'b0;
        arst_n_i = 1'b0;
        nc(2);
        `CHK(task_h, 72'h0);
        arst_n_i = 1'b1;
        nc(2);
        `CHK(task_h.limit, 16'hffff);
        `CHK(task_h.sel, 16'h0000);
        close_out();
    end
endmodule : stl_task_regs_tb_top
